// ===== core/comfort_noise.sv
// Comfort noise insertion for the nonlinear suppressor, with AHB-Lite regs.
// Assumes samples arrive on sample_valid strobes in the clock domain and
// that the suppressor decision and threshold come from outside this block.
//
// How it works
// - comfort_level_offset sets the gain applied to the measured level.
// - Subjective mode clamps send_output amplitude to the comfort level.
// - Larger rise step makes measured level higher and less stable.
// - Larger fall step makes measured level lower and less stable.
// - Louder of send in/out above send ceiling halts measurement.
// - Receive input above receive ceiling halts measurement.
// - Higher ceilings measure more often, lowering stability.
// - standard_noise_select 1 gives constant noise, 0 gives subjective.
// - In standard mode variant 1 band-limited noise, variant 0 silence.
// - Comfort signal replaces send only while the suppressor is active.
// - Protected writes need key 95H in the write-protect register.
// - Measured noise level readable at monitor index 24H.
// - Suppressor threshold readable at monitor index 27H.
module comfort_noise
  import comfort_noise_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Sample streams
  input  wire logic        sample_valid,
  input  wire logic [15:0] send_input,
  input  wire logic [15:0] send_cancelled,
  input  wire logic [15:0] receive_input,
  // Suppressor state
  input  wire logic        suppressor_active,
  input  wire logic [7:0]  suppressor_threshold,
  // Send output
  output logic      [15:0] send_output,
  output logic             send_output_valid
);

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // Register bus

  logic [7:0]  write_key_q;
  logic [7:0]  meter_cfg_q;
  logic [7:0]  ceiling_cfg_q;
  logic [7:0]  pcm_cfg_q;
  logic [7:0]  threshold_q;
  logic        wr_pend_q;
  logic [5:0]  wr_idx_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        addr_take;
  logic        addr_ok;
  logic        unlocked;
  logic [7:0]  wbyte;

  assign addr_take = hsel && htrans[1] && hready;
  // Only whole aligned words are mapped; others read zero, writes drop
  assign addr_ok   = (haddr[1:0] == 2'b00) && (hsize == 3'b010);
  assign unlocked  = (write_key_q == WRITE_KEY);
  assign wbyte     = hwdata[7:0];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  logic [15:0] noise_level;

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (addr_ok) begin
      case (haddr[7:2])
        IDX_NOISE_MONITOR:  rdata_d = {24'h000000, noise_level[15:8]};
        IDX_THRESH_MONITOR: rdata_d = {24'h000000, threshold_q};
        default:            rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_q   <= 32'h0000_0000;
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 6'h00;
    end else begin
      if (addr_take && !hwrite) begin
        rdata_q <= rdata_d;
      end
      wr_pend_q <= addr_take && hwrite && addr_ok;
      if (addr_take) begin
        wr_idx_q <= haddr[7:2];
      end
    end
  end

  assign hrdata = rdata_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      write_key_q <= KEY_RESET;
    end else if (wr_pend_q && wr_idx_q == IDX_WRITE_PROTECT) begin
      write_key_q <= wbyte;
    end
  end

  // Configuration registers accept writes only while the key is held
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meter_cfg_q   <= NOISE_METER_RESET;
      ceiling_cfg_q <= NOISE_CEIL_RESET;
      pcm_cfg_q     <= PCM_OUTPUT_RESET;
    end else if (wr_pend_q && unlocked) begin
      case (wr_idx_q)
        IDX_NOISE_METER:   meter_cfg_q   <= wbyte;
        IDX_NOISE_CEILING: ceiling_cfg_q <= wbyte;
        IDX_PCM_OUTPUT:    pcm_cfg_q     <= wbyte;
        default:           meter_cfg_q   <= meter_cfg_q;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      threshold_q <= 8'h00;
    end else begin
      threshold_q <= suppressor_threshold;
    end
  end

  // Field views

  logic [3:0] level_offset;
  logic [1:0] rise_step;
  logic [1:0] fall_step;
  logic [3:0] send_ceiling;
  logic [3:0] recv_ceiling;
  logic       std_select;
  logic       std_variant;

  assign level_offset = meter_cfg_q[OFFSET_LSB +: 4];
  assign rise_step    = meter_cfg_q[RISE_LSB +: 2];
  assign fall_step    = meter_cfg_q[FALL_LSB +: 2];
  assign send_ceiling = ceiling_cfg_q[SEND_CEIL_LSB +: 4];
  assign recv_ceiling = ceiling_cfg_q[RECV_CEIL_LSB +: 4];
  assign std_select   = pcm_cfg_q[STD_SELECT_BIT];
  assign std_variant  = pcm_cfg_q[STD_VARIANT_BIT];

  // Background noise measurement

  logic [15:0] send_out_q;
  logic [3:0]  send_lvl;
  logic [3:0]  recv_lvl;
  logic        measure_en;
  logic [15:0] cancelled_mag;

  assign cancelled_mag = magnitude(send_cancelled);

  // Louder of the send input and the last send output sample
  always_comb begin
    send_lvl = level_code(magnitude(send_input));
    if (level_code(magnitude(send_out_q)) > send_lvl) begin
      send_lvl = level_code(magnitude(send_out_q));
    end
  end

  assign recv_lvl   = level_code(magnitude(receive_input));
  // Higher ceilings let more signal count as noise
  assign measure_en = (send_lvl <= send_ceiling)
                   && (recv_lvl <= recv_ceiling);

  noise_meter meter (
    .clock       (clock),
    .rst         (rst),
    .sample_en   (sample_valid),
    .measure_en  (measure_en),
    .sample_mag  (cancelled_mag),
    .rise_step   (rise_step),
    .fall_step   (fall_step),
    .noise_level (noise_level)
  );

  // Comfort level: 1.5 dB per offset step, unity at offset 4, Q8 gain
  logic [10:0] gain;
  logic [26:0] scaled;
  logic [14:0] comfort;

  always_comb begin
    case (level_offset)
      4'h0:    gain = 11'd128;
      4'h1:    gain = 11'd152;
      4'h2:    gain = 11'd181;
      4'h3:    gain = 11'd215;
      4'h4:    gain = 11'd256;
      4'h5:    gain = 11'd304;
      4'h6:    gain = 11'd362;
      4'h7:    gain = 11'd431;
      4'h8:    gain = 11'd512;
      4'h9:    gain = 11'd609;
      4'ha:    gain = 11'd724;
      4'hb:    gain = 11'd861;
      4'hc:    gain = 11'd1024;
      4'hd:    gain = 11'd1218;
      4'he:    gain = 11'd1448;
      default: gain = 11'd1722;
    endcase
  end

  assign scaled  = 27'(noise_level) * 27'(gain);
  // Saturate so the amplitude always fits a signed sample
  assign comfort = (scaled[26:8] > 19'(AMP_MAX)) ? AMP_MAX : scaled[22:8];

  // Noise source; sign held two samples to halve the bandwidth
  logic [15:0] lfsr_q;
  logic        phase_q;
  logic        sign_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lfsr_q  <= LFSR_SEED;
      phase_q <= 1'b0;
      sign_q  <= 1'b0;
    end else if (sample_valid) begin
      lfsr_q  <= lfsr_q[0] ? ((lfsr_q >> 1) ^ LFSR_TAPS) : (lfsr_q >> 1);
      phase_q <= ~phase_q;
      if (phase_q) begin
        sign_q <= lfsr_q[0];
      end
    end
  end

  // Output selection

  logic [15:0] pos_lim;
  logic [15:0] neg_lim;
  logic [15:0] out_d;

  assign pos_lim = {1'b0, comfort};
  assign neg_lim = 16'(~pos_lim + 16'h0001);

  always_comb begin
    out_d = send_cancelled;
    if (suppressor_active) begin
      if (std_select) begin
        if (std_variant) begin
          out_d = sign_q ? neg_lim : pos_lim;
        end else begin
          out_d = 16'h0000;
        end
      end else if ($signed(send_cancelled) > $signed(pos_lim)) begin
        out_d = pos_lim;
      end else if ($signed(send_cancelled) < $signed(neg_lim)) begin
        out_d = neg_lim;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      send_out_q        <= 16'h0000;
      send_output_valid <= 1'b0;
    end else begin
      send_output_valid <= sample_valid;
      if (sample_valid) begin
        send_out_q <= out_d;
      end
    end
  end

  assign send_output = send_out_q;

  // Checks

  chk_pass_inactive: assert property (
    sample_valid && !suppressor_active
      |=> send_output == $past(send_cancelled))
    else $error("send path altered while suppressor idle");

  chk_dead_line: assert property (
    sample_valid && suppressor_active && std_select && !std_variant
      |=> send_output == 16'h0000 && send_output_valid)
    else $error("dead line mode produced non-zero output");

  chk_std_amplitude: assert property (
    sample_valid && suppressor_active && std_select && std_variant
      |=> magnitude(send_output) == {1'b0, $past(comfort)})
    else $error("standard noise amplitude not the comfort level");

  chk_subj_limit: assert property (
    sample_valid && suppressor_active && !std_select
      |=> magnitude(send_output) <= {1'b0, $past(comfort)})
    else $error("subjective output exceeds the comfort level");

  chk_meter_hold: assert property (
    !measure_en |=> $stable(noise_level))
    else $error("noise level moved while measurement halted");

  chk_recv_ceiling: assert property (
    sample_valid && level_code(magnitude(receive_input)) > recv_ceiling
      |=> $stable(noise_level))
    else $error("measurement ran above the receive ceiling");

  chk_key_reject: assert property (
    wr_pend_q && !unlocked
      |=> $stable(meter_cfg_q) && $stable(ceiling_cfg_q)
          && $stable(pcm_cfg_q))
    else $error("protected register written without key");

  chk_noise_monitor: assert property (
    addr_take && !hwrite && addr_ok && haddr[7:2] == IDX_NOISE_MONITOR
      |=> hrdata == {24'h000000, $past(noise_level[15:8])})
    else $error("noise monitor read returned wrong level");

  chk_thresh_monitor: assert property (
    addr_take && !hwrite && addr_ok && haddr[7:2] == IDX_THRESH_MONITOR
      |=> hrdata[7:0] == $past(suppressor_threshold, 2))
    else $error("threshold monitor read returned wrong value");

endmodule // comfort_noise

// ===== core/comfort_noise_pkg.sv
// Shared constants for the comfort noise and nonlinear suppressor block.
// Assumes a single 250 MHz clock and 16-bit linear PCM samples.
package comfort_noise_pkg;

  localparam int unsigned CLOCK_MHZ = 250;

  // Register indices; byte address on AHB is four times the index
  localparam logic [5:0] IDX_WRITE_PROTECT  = 6'h01;
  localparam logic [5:0] IDX_NOISE_METER    = 6'h18;
  localparam logic [5:0] IDX_NOISE_CEILING  = 6'h19;
  localparam logic [5:0] IDX_NOISE_MONITOR  = 6'h24;
  localparam logic [5:0] IDX_THRESH_MONITOR = 6'h27;
  localparam logic [5:0] IDX_PCM_OUTPUT     = 6'h30;

  localparam logic [7:0] WRITE_KEY          = 8'h95;

  // Values after reset
  localparam logic [7:0] KEY_RESET          = 8'h00;
  localparam logic [7:0] NOISE_METER_RESET  = 8'h8a;
  localparam logic [7:0] NOISE_CEIL_RESET   = 8'hee;
  localparam logic [7:0] PCM_OUTPUT_RESET   = 8'h03;
  localparam logic [15:0] NOISE_LEVEL_RESET = 16'h0040;

  // Field positions in noise_meter_config
  localparam int unsigned OFFSET_LSB = 0;   // comfort_level_offset [3:0]
  localparam int unsigned RISE_LSB   = 4;   // noise_meter_rise_step [5:4]
  localparam int unsigned FALL_LSB   = 6;   // noise_meter_fall_step [7:6]
  // Field positions in noise_ceiling_config
  localparam int unsigned SEND_CEIL_LSB = 0; // send_level_ceiling [3:0]
  localparam int unsigned RECV_CEIL_LSB = 4; // receive_level_ceiling [7:4]
  // Field positions in pcm_output_config
  localparam int unsigned STD_SELECT_BIT  = 0;
  localparam int unsigned STD_VARIANT_BIT = 1;

  // Meter tracking shift at step zero; larger steps shift less
  localparam logic [2:0] METER_BASE_SHIFT = 3'd6;
  localparam logic [15:0] LFSR_SEED       = 16'hace1;
  localparam logic [15:0] LFSR_TAPS       = 16'hb400;
  localparam logic [14:0] AMP_MAX         = 15'h7fff;

  // Magnitude of a signed sample
  function automatic logic [15:0] magnitude(input logic [15:0] s);
    magnitude = s[15] ? 16'(~s + 16'h0001) : s;
  endfunction

  // Level on a 0..15 log2 scale: position of the highest set bit
  function automatic logic [3:0] level_code(input logic [15:0] m);
    level_code = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (m[i]) begin
        level_code = 4'(i);
      end
    end
  endfunction

endpackage

// ===== core/noise_meter.sv
// Background noise level meter: slow asymmetric tracker of sample magnitude.
// Assumes sample_en marks one sample per frame and measure_en gates tracking.
module noise_meter
  import comfort_noise_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Samples and control
  input  wire logic        sample_en,
  input  wire logic        measure_en,
  input  wire logic [15:0] sample_mag,
  input  wire logic [1:0]  rise_step,
  input  wire logic [1:0]  fall_step,
  // Tracked level
  output logic      [15:0] noise_level
);

  logic [15:0] level_q;
  logic [15:0] level_d;
  logic [2:0]  up_shift;
  logic [2:0]  down_shift;
  logic [15:0] diff;

  assign up_shift   = METER_BASE_SHIFT - {1'b0, rise_step};
  assign down_shift = METER_BASE_SHIFT - {1'b0, fall_step};

  // Bigger rise step climbs faster: higher, less stable level
  // Bigger fall step drops faster: lower, less stable level
  always_comb begin
    level_d = level_q;
    diff    = 16'h0000;
    if (sample_mag > level_q) begin
      diff    = sample_mag - level_q;
      level_d = level_q + (diff >> up_shift) + 16'h0001;
    end else if (sample_mag < level_q) begin
      diff    = level_q - sample_mag;
      level_d = level_q - (diff >> down_shift) - 16'h0001;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      level_q <= NOISE_LEVEL_RESET;
    end else if (sample_en && measure_en) begin
      level_q <= level_d;
    end
  end

  assign noise_level = level_q;

endmodule // noise_meter

// ===== testbench/pcm_partner.sv
// PCM sample source and sink facing the comfort noise block.
// Assumes the block answers one clock after each sample strobe.
module pcm_partner (
  // Clock
  input  wire logic        clock,
  // Samples towards the block
  output logic             sample_valid,
  output logic      [15:0] send_input,
  output logic      [15:0] send_cancelled,
  output logic      [15:0] receive_input,
  output logic             suppressor_active,
  // Send output from the block
  input  wire logic [15:0] send_output,
  input  wire logic        send_output_valid
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sample_valid = 1'b0;
    send_input = 16'h0000;
    send_cancelled = 16'h0000;
    receive_input = 16'h0000;
    suppressor_active = 1'b0;
  end

  // Between strobes the data lines carry the inverse, so a stale sample
  // taken without a strobe would show up as a wrong output
  task automatic xfer(input logic [15:0] sc, input logic [15:0] si,
                      input logic [15:0] ri, input logic act,
                      output logic [15:0] so, output logic vld);
    @(posedge clock);
    sample_valid      <= 1'b1;
    send_cancelled    <= sc;
    send_input        <= si;
    receive_input     <= ri;
    suppressor_active <= act;
    @(posedge clock);
    sample_valid   <= 1'b0;
    send_cancelled <= ~sc;
    send_input     <= ~si;
    receive_input  <= ~ri;
    #1;
    so  = send_output;
    vld = send_output_valid;
  endtask
endmodule // pcm_partner

// ===== testbench/comfort_noise_test.sv
// Self-checking bench for the comfort noise block over AHB-Lite.
// Assumes the block and its package from core/ and the PCM partner model.
module comfort_noise_test
  import comfort_noise_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clock, rst, hsel, hwrite, hreadyout, hresp;
  logic [7:0]  haddr, suppressor_threshold;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic        sample_valid, suppressor_active, send_output_valid, vld;
  logic [15:0] send_input, send_cancelled, receive_input, send_output, so;
  logic [15:0] a1, a2, a8;
  logic [7:0]  m0;
  logic [15:0] pass [3] = '{16'h1234, 16'h8001, 16'h7fff};
  logic [7:0]  subj [2] = '{8'h00, 8'h02};
  wire         hready = hreadyout;
  int          err_count, compares;

  comfort_noise i_dut (
    .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .sample_valid(sample_valid), .send_input(send_input),
    .send_cancelled(send_cancelled), .receive_input(receive_input),
    .suppressor_active(suppressor_active),
    .suppressor_threshold(suppressor_threshold),
    .send_output(send_output), .send_output_valid(send_output_valid)
  );

  pcm_partner i_pcm (
    .clock(clock), .sample_valid(sample_valid), .send_input(send_input),
    .send_cancelled(send_cancelled), .receive_input(receive_input),
    .suppressor_active(suppressor_active), .send_output(send_output),
    .send_output_valid(send_output_valid)
  );

  always #2 clock = ~clock;

  function automatic logic [15:0] mag(input logic [15:0] s);
    return s[15] ? 16'(-s) : s;
  endfunction

  task automatic chk_val(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_range(input string name, input logic [31:0] lo,
                           input logic [31:0] hi, input logic [31:0] got);
    compares++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      err_count++;
      $display("MISMATCH %s expected %h..%h seen %h", name, lo, hi, got);
    end
  endtask

  // One single word transfer; waits on hready in both phases
  task automatic ahb(input logic wr, input logic [5:0] idx,
                     input logic [7:0] wd, output logic [31:0] data);
    @(posedge clock);
    hsel   <= 1'b1;
    haddr  <= {idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize  <= 3'b010;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    data = hrdata;
  endtask

  task automatic report_and_stop();
    if (err_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #40000;
    err_count++;
    report_and_stop();
  end

  initial begin
    clock = 1'b0;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    suppressor_threshold = 8'h5a;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    ahb(1'b0, IDX_NOISE_MONITOR, 8'h00, rd);
    chk_val("noise_level_monitor", 32'h0, rd);
    ahb(1'b0, IDX_THRESH_MONITOR, 8'h00, rd);
    chk_val("threshold_monitor", 32'h5a, rd);
    suppressor_threshold <= 8'hc3;
    ahb(1'b0, IDX_THRESH_MONITOR, 8'h00, rd);
    chk_val("threshold_monitor", 32'hc3, rd);
    ahb(1'b0, 6'h02, 8'h00, rd);
    chk_val("unmapped_read", 32'h0, rd);
    chk_val("hresp", 32'h0, 32'(hresp));
    foreach (pass[i]) begin
      i_pcm.xfer(pass[i], 16'h0, 16'h0, 1'b0, so, vld);
      chk_val("passthrough", 32'(pass[i]), 32'(so));
      chk_val("send_output_valid", 32'h1, 32'(vld));
    end
    // Let the meter settle on a steady 2000h background
    repeat (300) i_pcm.xfer(16'h2000, 16'h0, 16'h0, 1'b0, so, vld);
    ahb(1'b0, IDX_NOISE_MONITOR, 8'h00, rd);
    chk_range("noise_level_monitor", 32'h1c, 32'h20, rd);
    ahb(1'b1, IDX_PCM_OUTPUT, 8'h01, rd);
    i_pcm.xfer(16'h2000, 16'h0, 16'h0, 1'b1, so, vld);
    chk_range("unkeyed_write", 32'h1, 32'h7fff, 32'(mag(so)));
    ahb(1'b1, IDX_WRITE_PROTECT, WRITE_KEY, rd);
    ahb(1'b1, IDX_NOISE_CEILING, 8'h0e, rd);
    ahb(1'b0, IDX_NOISE_MONITOR, 8'h00, rd);
    m0 = rd[7:0];
    // Receive input above its ceiling keeps the level frozen until the ceiling is rewritten
    repeat (40) i_pcm.xfer(16'h0, 16'h0, 16'h0100, 1'b0, so, vld);
    ahb(1'b0, IDX_NOISE_MONITOR, 8'h00, rd);
    chk_val("frozen_by_receive", 32'(m0), rd);
    ahb(1'b1, IDX_PCM_OUTPUT, 8'h01, rd);
    i_pcm.xfer(16'h2000, 16'h0, 16'h0100, 1'b1, so, vld);
    chk_val("dead_line", 32'h0, 32'(so));
    ahb(1'b1, IDX_PCM_OUTPUT, 8'h03, rd);
    ahb(1'b1, IDX_NOISE_METER, 8'h82, rd);
    i_pcm.xfer(16'h0, 16'h0, 16'h0100, 1'b1, so, vld);
    a1 = mag(so);
    i_pcm.xfer(16'h0, 16'h0, 16'h0100, 1'b1, so, vld);
    a2 = mag(so);
    chk_val("constant_amplitude", 32'(a1), 32'(a2));
    chk_range("amp_offset_2", m0 * 179, (m0 + 1) * 182, 32'(a2));
    ahb(1'b1, IDX_NOISE_METER, 8'h88, rd);
    i_pcm.xfer(16'h0, 16'h0, 16'h0100, 1'b1, so, vld);
    a8 = mag(so);
    chk_range("amp_offset_8", m0 * 500, (m0 + 1) * 514, 32'(a8));
    foreach (subj[i]) begin
      ahb(1'b1, IDX_PCM_OUTPUT, subj[i], rd);
      i_pcm.xfer(16'h0100, 16'h0, 16'h0100, 1'b1, so, vld);
      chk_val("subjective_small", 32'h0100, 32'(so));
      i_pcm.xfer(16'h7fff, 16'h0, 16'h0100, 1'b1, so, vld);
      chk_val("subjective_clamp", 32'(a8), 32'(so));
      i_pcm.xfer(16'h8001, 16'h0, 16'h0100, 1'b1, so, vld);
      chk_val("subjective_clamp_neg", 32'(16'(-a8)), 32'(so));
      i_pcm.xfer(16'h7fff, 16'h0, 16'h0100, 1'b0, so, vld);
      chk_val("inactive_subjective", 32'h7fff, 32'(so));
    end
    ahb(1'b1, IDX_NOISE_CEILING, 8'he3, rd);
    ahb(1'b0, IDX_NOISE_MONITOR, 8'h00, rd);
    m0 = rd[7:0];
    repeat (40) i_pcm.xfer(16'h0, 16'h7000, 16'h0, 1'b0, so, vld);
    ahb(1'b0, IDX_NOISE_MONITOR, 8'h00, rd);
    chk_val("frozen_by_send", 32'(m0), rd);
    ahb(1'b1, IDX_NOISE_CEILING, 8'hee, rd);
    repeat (40) i_pcm.xfer(16'h0, 16'h0, 16'h0, 1'b0, so, vld);
    ahb(1'b0, IDX_NOISE_MONITOR, 8'h00, rd);
    chk_range("level_falls", 32'h0, 32'(m0) - 1, rd);
    // Largest rise step climbs back within a few samples
    ahb(1'b1, IDX_NOISE_METER, 8'hb8, rd);
    repeat (10) i_pcm.xfer(16'h2000, 16'h0, 16'h0, 1'b0, so, vld);
    ahb(1'b0, IDX_NOISE_MONITOR, 8'h00, rd);
    chk_range("fast_rise", 32'h14, 32'h20, rd);
    report_and_stop();
  end
endmodule // comfort_noise_test
